// ### rtl/aloc_ctrl.sv
// list offset registers, address forming and sample/hold sequencer on AXI4-Lite
`timescale 1ns/1ps
`include "aloc_map.svh"
module aloc_ctrl
    import aloc_pkg::*;
#(
    parameter int NCH = 16,
    parameter int MAXBITS = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comp_in,
    output logic [NCH-1:0] chan_sel,
    output aloc_switch_type sw,
    output logic [MAXBITS-1:0] dac_code,
    output aloc_addr_type addr,
    output logic conv_busy
);
    // elaboration checks: channel field is 5 bits, sar datapath fixed at 12
    if (NCH < 2 || NCH > 32) $error("NCH out of range");
    if (MAXBITS != 12) $error("MAXBITS must be 12");

    // bus state
    logic [7:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    // software registers
    logic [31:0] ctrl_q;
    logic [6:0] off1_q; // list one offset, objects
    logic [23:0] cmd_base_q;
    logic [23:0] res_base_q;
    logic [5:0] idx_q;
    logic start_q; // one-cycle start pulse
    // sequencer
    aloc_phase_type phase_q;
    logic [4:0] cnt_q;
    logic [4:0] smp_q; // latched total sample cycles
    logic [3:0] bit_q;
    logic [11:0] sar_q;
    logic [11:0] result_q;
    logic done_flag_q;
    logic wr_fire;

    // field views
    logic en;
    logic smod;
    logic lsel;
    logic [4:0] smp_sel;
    logic [4:0] ch_sel;
    logic [1:0] res_sel;
    assign en = ctrl_q[`ALOC_CTRL_EN];
    assign smod = ctrl_q[`ALOC_CTRL_SMOD];
    assign lsel = ctrl_q[`ALOC_CTRL_LSEL];
    assign smp_sel = ctrl_q[`ALOC_CTRL_SMP_HI:`ALOC_CTRL_SMP_LO];
    assign ch_sel = ctrl_q[`ALOC_CTRL_CH_HI:`ALOC_CTRL_CH_LO];
    assign res_sel = ctrl_q[`ALOC_CTRL_RES_HI:`ALOC_CTRL_RES_LO];

    // byte-lane merge of a written word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // object count to byte offset
    function automatic logic [23:0] objs(input logic [6:0] n, input int sh);
        return 24'(n) << sh;
    endfunction

    // offset selected by list choice; list zero is a hard zero
    function automatic logic [6:0] sel_off(input logic s, input logic [6:0] o1);
        return s ? o1 : `ALOC_OFFSET_RESET;
    endfunction

    // result bit count from resolution code
    function automatic logic [3:0] nbits(input logic [1:0] r);
        case (r)
            2'h0: return 4'h8;
            2'h1: return 4'hA;
            default: return 4'hC;
        endcase
    endfunction

    // write address and data captured in either order
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
                `ALOC_OFF_LIST0, `ALOC_OFF_LIST1, `ALOC_OFF_CTRL, `ALOC_OFF_CMD_BASE,
                `ALOC_OFF_RES_BASE, `ALOC_OFF_INDEX, `ALOC_OFF_START: s_axi_bresp <= 2'h0;
                default: s_axi_bresp <= 2'h2;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control and pointer registers; pointers lock while enabled with smod clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `ALOC_CTRL_RESET;
            off1_q <= `ALOC_OFFSET_RESET;
            cmd_base_q <= 24'h00_0000;
            res_base_q <= 24'h00_0000;
            idx_q <= 6'h00;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_fire) begin
                case (awaddr_q)
                    `ALOC_OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
                    `ALOC_OFF_LIST1: begin
                        // the byte lane is lane 0 of the aligned word
                        if ((!en || smod) && wstrb_q[0]) off1_q <= wdata_q[6:0];
                    end
                    `ALOC_OFF_CMD_BASE: if (!en || smod) cmd_base_q <= {wdata_q[23:2], 2'h0};
                    `ALOC_OFF_RES_BASE: if (!en || smod) res_base_q <= {wdata_q[23:1], 1'h0};
                    `ALOC_OFF_INDEX: if (!en || smod) idx_q <= wdata_q[5:0];
                    `ALOC_OFF_START: start_q <= wdata_q[0] && en;
                    default: ; // list zero and unmapped ignore writes
                endcase
            end
        end
    end

    // read channel; list zero offset always reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000; // unmapped places read zero
            case (s_axi_araddr)
                `ALOC_OFF_LIST0: s_axi_rdata <= 32'h0000_0000;
                `ALOC_OFF_LIST1: s_axi_rdata <= {25'h0, off1_q};
                `ALOC_OFF_CTRL: s_axi_rdata <= ctrl_q;
                `ALOC_OFF_CMD_BASE: s_axi_rdata <= {8'h00, cmd_base_q};
                `ALOC_OFF_RES_BASE: s_axi_rdata <= {8'h00, res_base_q};
                `ALOC_OFF_INDEX: s_axi_rdata <= {26'h0, idx_q};
                `ALOC_OFF_STATUS: s_axi_rdata <= {26'h0, phase_q};
                `ALOC_OFF_RESULT: s_axi_rdata <= {19'h0, done_flag_q, result_q};
                default: s_axi_rresp <= 2'h2;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // fetch and store addresses from base, selected offset and index
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr <= '0;
        end else begin
            addr.cmd_addr <= cmd_base_q + objs(sel_off(lsel, off1_q), `ALOC_CMD_SHIFT)
                + objs({1'b0, idx_q}, `ALOC_CMD_SHIFT);
            addr.res_addr <= res_base_q + objs(sel_off(lsel, off1_q), `ALOC_RES_SHIFT)
                + objs({1'b0, idx_q}, `ALOC_RES_SHIFT);
        end
    end

    // phase sequencer: pump, buffered, direct, convert
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= ALOC_IDLE;
            cnt_q <= 5'h00;
            smp_q <= `ALOC_SMP_BASE;
        end else begin
            cnt_q <= cnt_q + 5'h01; // default count, exits from idle, pump, buffered and direct reload it
            case (phase_q)
                ALOC_IDLE: begin
                    if (start_q) begin
                        phase_q <= ALOC_PUMP;
                        cnt_q <= 5'h01;
                        // reserved codes clamp to longest legal time
                        smp_q <= (smp_sel > `ALOC_SMP_MAX) ? `ALOC_SMP_MAX + `ALOC_SMP_BASE
                                 : smp_sel + `ALOC_SMP_BASE;
                    end
                end
                ALOC_PUMP: begin
                    if (cnt_q == 5'({1'b0, `ALOC_PUMP_CYCLES})) begin
                        phase_q <= ALOC_SBUF;
                        cnt_q <= 5'h01;
                    end
                end
                ALOC_SBUF: begin
                    if (cnt_q == `ALOC_BUF_CYCLES) begin
                        phase_q <= ALOC_SDIR;
                        cnt_q <= 5'h01;
                    end
                end
                ALOC_SDIR: begin
                    // remainder of total sample time
                    if (cnt_q == smp_q - `ALOC_BUF_CYCLES) begin
                        phase_q <= ALOC_CONV;
                        cnt_q <= 5'h00;
                    end
                end
                ALOC_CONV: if (bit_q == 4'h0) phase_q <= ALOC_DONE; // last bit taken
                ALOC_DONE: phase_q <= ALOC_IDLE;
                default: phase_q <= ALOC_IDLE;
            endcase
        end
    end

    // successive approximation, one comparator sample per bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_q <= 4'h0;
            sar_q <= 12'h000;
            result_q <= 12'h000;
            done_flag_q <= 1'b0;
        end else begin
            if (phase_q == ALOC_SDIR && cnt_q == smp_q - `ALOC_BUF_CYCLES) begin
                bit_q <= nbits(res_sel);
                sar_q <= 12'h800; // trial msb
                done_flag_q <= 1'b0;
            end else if (phase_q == ALOC_CONV && bit_q != 4'h0) begin
                // keep or drop trial bit, set next one
                if (!comp_in) sar_q[11 - (nbits(res_sel) - bit_q)] <= 1'b0;
                if (bit_q != 4'h1) sar_q[10 - (nbits(res_sel) - bit_q)] <= 1'b1;
                bit_q <= bit_q - 4'h1;
            end else if (phase_q == ALOC_DONE) begin
                result_q <= sar_q >> (4'hC - nbits(res_sel)); // right justified
                done_flag_q <= 1'b1;
            end
        end
    end

    // analog switch and channel drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw <= '0;
            chan_sel <= '0;
            dac_code <= '0;
            conv_busy <= 1'b0;
        end else begin
            sw.pump <= (phase_q == ALOC_PUMP);
            sw.buf_conn <= (phase_q == ALOC_SBUF);
            sw.dir_conn <= (phase_q == ALOC_SDIR);
            sw.hold <= (phase_q == ALOC_CONV);
            chan_sel <= (phase_q == ALOC_SBUF || phase_q == ALOC_SDIR)
                ? NCH'(1) << (6'(ch_sel) % 6'(NCH)) : '0;
            dac_code <= sar_q;
            conv_busy <= !(phase_q == ALOC_IDLE);
        end
    end

    // switches never overlap and channel select is one-hot or off
    property p_switch_exclusive;
        @(posedge clk) disable iff (rst)
        $onehot0({sw.pump, sw.buf_conn, sw.dir_conn, sw.hold}) && $onehot0(chan_sel);
    endproperty
    a_switch_exclusive: assert property (p_switch_exclusive)
        else $error("switches overlap");
    property p_buf_two;
        @(posedge clk) disable iff (rst)
        $rose(sw.buf_conn) |-> sw.buf_conn[*2] ##1 (!sw.buf_conn && sw.dir_conn);
    endproperty
    a_buf_two: assert property (p_buf_two)
        else $error("buffered period not two cycles");
    property p_pump_two;
        @(posedge clk) disable iff (rst)
        $rose(sw.pump) |-> sw.pump[*2] ##1 sw.buf_conn;
    endproperty
    a_pump_two: assert property (p_pump_two)
        else $error("pump phase not two cycles");
    property p_hold_disc;
        @(posedge clk) disable iff (rst)
        sw.hold |-> (chan_sel == '0) && !sw.buf_conn && !sw.dir_conn;
    endproperty
    a_hold_disc: assert property (p_hold_disc)
        else $error("input connected during hold");
    property p_list0_zero;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `ALOC_OFF_LIST0)
            |=> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_list0_zero: assert property (p_list0_zero)
        else $error("list zero offset not zero");
    property p_lock;
        @(posedge clk) disable iff (rst)
        (en && !smod) |=> $stable(off1_q);
    endproperty
    a_lock: assert property (p_lock)
        else $error("offset changed while locked");
    // inputs unchanged for one edge, so the registered address reflects them now
    property p_addr;
        @(posedge clk) disable iff (rst)
        $stable(lsel) && $stable(off1_q) && $stable(cmd_base_q) && $stable(idx_q)
            |-> addr.cmd_addr == cmd_base_q + (lsel ? 24'(off1_q) << 2 : 24'h0)
                + (24'(idx_q) << 2);
    endproperty
    a_addr: assert property (p_addr)
        else $error("command address wrong");
    property p_direct_follows;
        @(posedge clk) disable iff (rst)
        $fell(sw.dir_conn) |-> sw.hold;
    endproperty
    a_direct_follows: assert property (p_direct_follows)
        else $error("direct period not followed by hold");

endmodule // aloc_ctrl

// ### rtl/aloc_map.svh
// register offsets, field positions and timing counts for the list offset and sample control
`ifndef ALOC_MAP_SVH
`define ALOC_MAP_SVH
// list offsets are kept as word indices; the bus sees four times the index
`define ALOC_IDX_LIST0 8'h24
`define ALOC_IDX_LIST1 8'h25
`define ALOC_OFF_LIST0 (`ALOC_IDX_LIST0 << 2)
`define ALOC_OFF_LIST1 (`ALOC_IDX_LIST1 << 2)
`define ALOC_OFF_CTRL 8'h28
`define ALOC_OFF_CMD_BASE 8'h2C
`define ALOC_OFF_RES_BASE 8'h30
`define ALOC_OFF_INDEX 8'h34
`define ALOC_OFF_START 8'h38
`define ALOC_OFF_STATUS 8'h3C
`define ALOC_OFF_RESULT 8'h40
`define ALOC_CTRL_EN 0
`define ALOC_CTRL_SMOD 1
`define ALOC_CTRL_LSEL 2
`define ALOC_CTRL_SMP_LO 8
`define ALOC_CTRL_SMP_HI 12
`define ALOC_CTRL_CH_LO 16
`define ALOC_CTRL_CH_HI 20
`define ALOC_CTRL_RES_LO 24
`define ALOC_CTRL_RES_HI 25
`define ALOC_CTRL_RESET 32'h0000_0000
`define ALOC_OFFSET_RESET 7'h00
`define ALOC_PUMP_CYCLES 4'h2
`define ALOC_BUF_CYCLES 5'h02
`define ALOC_SMP_BASE 5'h04
`define ALOC_SMP_MAX 5'h14
`define ALOC_CMD_SHIFT 2
`define ALOC_RES_SHIFT 1
`endif

// ### rtl/aloc_pkg.sv
// types shared by the list offset and sample control block
package aloc_pkg;
    // converter phase, one-hot
    typedef enum logic [5:0] {
        ALOC_IDLE = 6'b000001,
        ALOC_PUMP = 6'b000010,
        ALOC_SBUF = 6'b000100,
        ALOC_SDIR = 6'b001000,
        ALOC_CONV = 6'b010000,
        ALOC_DONE = 6'b100000
    } aloc_phase_type;
    // analog switch controls toward the sample node
    typedef struct packed {
        logic pump;
        logic buf_conn;
        logic dir_conn;
        logic hold;
    } aloc_switch_type;
    // memory addresses formed for the list engine
    typedef struct packed {
        logic [23:0] cmd_addr;
        logic [23:0] res_addr;
    } aloc_addr_type;
endpackage

// ### tb/aloc_ctrl_tb_top.sv
// self-checking bench for the list offset registers and the sample/hold sequencer
`timescale 1ns/1ps
`include "aloc_map.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %s exp=%h got=%h", nm, exp, got); end end
module aloc_ctrl_tb_top
    import aloc_pkg::*;
;
    logic clk; // 100 MHz bench clock
    logic rst; // async reset, active high
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic comp_in; // comparator answer fed to the sar loop
    logic [15:0] chan_sel;
    aloc_switch_type sw;
    logic [11:0] dac_code;
    aloc_addr_type addr;
    logic conv_busy;
    int mismatches; // failed comparisons
    int tests_run; // comparisons made
    logic [31:0] rd; // last read data
    logic [1:0] rr; // last response code
    logic [15:0] exp_ch; // channel expected on the mux
    // per-conversion phase monitor counts, cleared off the clock edge
    int cyc, n_pump, n_buf, n_dir, n_hold, n_ch, n_bad;
    int last_pump, first_buf, last_buf, first_dir, last_dir, first_hold;
    // sample codes, channels, resolutions and comparator levels per run
    // the last code is reserved and must clamp to the longest sample time
    logic [4:0] codes [4] = '{5'h00, 5'h05, 5'h14, 5'h1F};
    logic [4:0] chans [4] = '{5'h00, 5'h07, 5'h0F, 5'h03};
    logic [1:0] ress [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic comps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    aloc_ctrl #(.NCH(16), .MAXBITS(12)) dut_u (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .comp_in(comp_in), .chan_sel(chan_sel),
        .sw(sw), .dac_code(dac_code), .addr(addr), .conv_busy(conv_busy)
    );

    // free-running clock
    always #5 clk = ~clk;

    // verdict and end of run
    task automatic summarize();
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one axi write; both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // extra edge keeps the next call from reassigning in this step
        if (n == 64) begin
            mismatches++;
            summarize();
        end else @(posedge clk);
    endtask

    // one axi read; rready held until the answer is sampled
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 64) begin
            mismatches++;
            summarize();
        end else @(posedge clk);
    endtask

    // phase monitor; sw is checked for order, length and exclusivity
    always @(posedge clk) begin
        cyc++;
        if (sw.pump) begin
            n_pump++;
            last_pump = cyc;
        end
        if (sw.buf_conn) begin
            n_buf++;
            if (n_buf == 1) first_buf = cyc;
            last_buf = cyc;
        end
        if (sw.dir_conn) begin
            n_dir++;
            if (n_dir == 1) first_dir = cyc;
            last_dir = cyc;
        end
        if (sw.hold) begin
            n_hold++;
            if (n_hold == 1) first_hold = cyc;
        end
        // two switches at once would short the node
        if ($countones(sw) > 1) n_bad++;
        if (chan_sel === exp_ch) n_ch++;
        else if (chan_sel !== 16'h0000) n_bad++;
    end

    // main sequence
    initial begin
        logic [11:0] e;
        int k;
        int nb; // result bits of this run
        int smp; // expected total sample cycles
        clk = 1'b0;
        rst = 1'b1;
        cyc = 0;
        exp_ch = 16'h0000;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        comp_in = 1'b0;
        mismatches = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values and the fixed zero offset
        axi_rd(`ALOC_OFF_LIST0, rd, rr);
        `CHK("list0_rst", 8'h00, rd[7:0])
        axi_rd(`ALOC_OFF_LIST1, rd, rr);
        `CHK("list1_rst", 7'h00, rd[6:0])
        axi_rd(`ALOC_OFF_CTRL, rd, rr);
        `CHK("ctrl_rst", 32'h0000_0000, rd)
        axi_wr(`ALOC_OFF_LIST0, 32'h0000_007F, rr);
        `CHK("list0_bresp", 2'h0, rr)
        axi_rd(`ALOC_OFF_LIST0, rd, rr);
        `CHK("list0_wr", 8'h00, rd[7:0])
        // list one offset: open while disabled, locked when enabled with smod clear, open again with smod set
        axi_wr(`ALOC_OFF_LIST1, 32'h0000_0015, rr);
        axi_rd(`ALOC_OFF_LIST1, rd, rr);
        `CHK("list1_off", 7'h15, rd[6:0])
        axi_wr(`ALOC_OFF_CTRL, 32'h0000_0001, rr);
        axi_wr(`ALOC_OFF_LIST1, 32'h0000_0033, rr);
        axi_rd(`ALOC_OFF_LIST1, rd, rr);
        `CHK("list1_lock", 7'h15, rd[6:0])
        axi_wr(`ALOC_OFF_CTRL, 32'h0000_0003, rr);
        axi_wr(`ALOC_OFF_LIST1, 32'h0000_0033, rr);
        axi_rd(`ALOC_OFF_LIST1, rd, rr);
        `CHK("list1_smod", 7'h33, rd[6:0])
        // unmapped place answers with slave error both ways
        axi_wr(8'h80, 32'h0000_0001, rr);
        `CHK("bresp_unmapped", 2'h2, rr)
        axi_rd(8'h80, rd, rr);
        `CHK("rresp_unmapped", 2'h2, rr)
        // address forming for both lists, offsets counted in objects
        axi_wr(`ALOC_OFF_CMD_BASE, 32'h0000_1000, rr);
        axi_wr(`ALOC_OFF_RES_BASE, 32'h0000_2000, rr);
        axi_wr(`ALOC_OFF_INDEX, 32'h0000_0003, rr);
        axi_rd(`ALOC_OFF_STATUS, rd, rr);
        `CHK("status_idle", 32'(ALOC_IDLE), rd)
        `CHK("addr_list0", {24'h00100C, 24'h002006}, addr)
        axi_wr(`ALOC_OFF_CTRL, 32'h0000_0007, rr);
        axi_rd(`ALOC_OFF_STATUS, rd, rr);
        `CHK("addr_list1", {24'h0010D8, 24'h00206C}, addr)
        // conversions across sample codes, channels and resolutions
        for (int i = 0; i < 4; i++) begin
            exp_ch = 16'h0001 << chans[i];
            comp_in <= comps[i];
            axi_wr(`ALOC_OFF_CTRL, {6'h00, ress[i], 3'h0, chans[i], 3'h0, codes[i], 8'h01}, rr);
            @(negedge clk);
            {n_pump, n_buf, n_dir, n_hold, n_ch, n_bad} = '0;
            {last_pump, first_buf, last_buf, first_dir, last_dir, first_hold} = '0;
            @(posedge clk);
            axi_wr(`ALOC_OFF_START, 32'h0000_0001, rr);
            for (k = 0; k < 300; k++) begin
                @(posedge clk);
                if (conv_busy === 1'b0 && sw === 4'h0) break;
            end
            if (k == 300) begin
                mismatches++;
                summarize();
            end
            nb = (ress[i] == 2'h0) ? 8 : (ress[i] == 2'h1) ? 10 : 12;
            smp = (codes[i] > `ALOC_SMP_MAX) ? 24 : int'(codes[i]) + 4;
            e = comps[i] ? (12'hFFF >> (12 - nb)) : 12'h000;
            `CHK("pump_len", 2, n_pump)
            `CHK("buf_len", 2, n_buf)
            `CHK("dir_len", smp - 2, n_dir)
            `CHK("hold_len", nb + 1, n_hold)
            `CHK("pump_to_buf", last_pump + 1, first_buf)
            `CHK("buf_to_dir", last_buf + 1, first_dir)
            `CHK("dir_to_hold", last_dir + 1, first_hold)
            `CHK("chan_cycles", smp, n_ch)
            `CHK("dac_code", e << (12 - nb), dac_code)
            `CHK("chan_or_sw_bad", 0, n_bad)
            axi_rd(`ALOC_OFF_RESULT, rd, rr);
            `CHK("result", {1'b1, e}, rd[12:0])
        end
        summarize();
    end
endmodule // aloc_ctrl_tb_top
